// [hdl/sdv_params.svh]
/*
 * Holds the register offsets, reset values, field positions and timing
 * figures of the start-up delay and voltage code block.
 * Assumes it is included by bare name and that the core clock runs at 100 MHz.
 */
`ifndef SDV_PARAMS_SVH
`define SDV_PARAMS_SVH

// ==========================================================================
// register offsets
`define SDV_ADDR_DLY34      8'h08
`define SDV_ADDR_DLY56      8'h09
`define SDV_ADDR_DLY78      8'h0A
`define SDV_ADDR_VOLT1      8'h0B
`define SDV_ADDR_VOLT2      8'h0C
`define SDV_ADDR_VOLT3      8'h0D
`define SDV_ADDR_VOLT4      8'h0E

// ==========================================================================
// reset values
`define SDV_RST_DLY34       8'h00
`define SDV_RST_DLY56       8'h10
`define SDV_RST_DLY78       8'h01
`define SDV_RST_VOLT1       8'h04
`define SDV_RST_VOLT2       8'h06
`define SDV_RST_VOLT3       8'h06
`define SDV_RST_VOLT4       8'h10

// ==========================================================================
// field layout
`define SDV_HI_LSB          3
`define SDV_LO_LSB          0
`define SDV_DLY_MASK        8'h3F
`define SDV_V4_MASK         8'h0F
`define SDV_V5_MASK         8'h1F
`define SDV_NCH             8
`define SDV_NREG            4

// ==========================================================================
// timing: one tick is 52.5 us, the delay codes are whole multiples of it
`define SDV_CLK_PERIOD_NS   10
`define SDV_TICK_NS         52500
`define SDV_DLY_C0          10'h000
`define SDV_DLY_C1          10'h028
`define SDV_DLY_C2          10'h03C
`define SDV_DLY_C3          10'h064
`define SDV_DLY_C4          10'h078
`define SDV_DLY_C5          10'h0A0
`define SDV_DLY_C6          10'h140
`define SDV_DLY_C7          10'h280
`define SDV_STEP_SHORT      2'h1
`define SDV_STEP_LONG       2'h2

`endif

// [hdl/sdv_pkg.sv]
/*
 * Types shared by the start-up delay and voltage code block.
 * Assumes nothing of its surroundings.
 */
package sdv_pkg;
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        SDV_IDLE = 4'b0001,
        SDV_RUN  = 4'b0010,
        SDV_ON   = 4'b0100,
        SDV_DOWN = 4'b1000
    } sdv_state_e;
    typedef logic [2:0] sdv_delay_t;
    typedef logic [9:0] sdv_ticks_t;
    typedef logic [4:0] sdv_vcode_t;
endpackage : sdv_pkg

// [hdl/sdv_ramp_if.sv]
/*
 * Carries one regulator's voltage target, step pacing and present code
 * between the register side and the voltage stepper.
 * Assumes both ends sit on core_clk.
 */
`timescale 1ns/1ps
interface sdv_ramp_if;
    logic [4:0] target;
    logic [4:0] level;
    logic       tick;
    logic       step_long;
    modport owner   (output target, output tick, output step_long, input level);
    modport stepper (input target, input tick, input step_long, output level);
endinterface : sdv_ramp_if

// [hdl/sdv_tick_div.sv]
/*
 * Divides core_clk down to one-cycle tick enables.
 * Assumes a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "sdv_params.svh"
module sdv_tick_div
    import sdv_pkg::*;
#(
    parameter int CYCLES = 5250,
    parameter int W      = 13
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // tick enable
    output logic      tick
);
    logic [W-1:0] cnt;

    // free-running count, tick on wrap
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == W'(CYCLES - 1)) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : sdv_tick_div

// [hdl/sdv_vstep.sv]
/*
 * Moves one regulator's output code toward its target one code per step.
 * Assumes tick is a one-cycle enable every 52.5 us.
 */
`timescale 1ns/1ps
`include "sdv_params.svh"
module sdv_vstep
    import sdv_pkg::*;
#(
    parameter sdv_vcode_t RESET_CODE = 5'h00
) (
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   rst,
    // ramp carrier
    sdv_ramp_if.stepper rp
);
    logic [1:0] wait_cnt;
    logic [1:0] step_len;

    // one step lasts one or two ticks
    assign step_len = rp.step_long ? `SDV_STEP_LONG : `SDV_STEP_SHORT;

    // step the level one code at a time
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rp.level <= RESET_CODE;
            wait_cnt <= 2'h0;
        end else if (rp.level == rp.target) begin
            wait_cnt <= 2'h0;
        end else if (rp.tick) begin
            if (wait_cnt + 2'h1 >= step_len) begin
                wait_cnt <= 2'h0;
                rp.level <= (rp.target > rp.level) ? rp.level + 5'h01 : rp.level - 5'h01;
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule : sdv_vstep

// [hdl/sdv_seq_top.sv]
/*
 * Start-up delay and voltage code block of a multi-channel power manager.
 * Holds the delay and voltage code registers, runs the enable-driven
 * start-up and shutdown sequence and steps the regulator voltage codes.
 * Assumes a register port on core_clk and an asynchronous enable pin.
 */
// Functional notes
// - each 3-bit delay code waits 0, 2.1, 3.15, 5.25, 6.3, 8.4, 16.8 or 33.6 ms before its channel starts.
// - the ch3/ch4 delay register holds ch4 in bits 5:3 and ch3 in bits 2:0, both reset to 000.
// - the second load switch uses bits 5:3 of its delay register, reset 010 for 3.15 ms.
// - the first load switch uses bits 2:0 of that register, reset 000.
// - the second external LDO monitor uses bits 5:3 of its delay register, reset 000.
// - the first external LDO monitor uses bits 2:0 of that register, reset 001 for 2.1 ms.
// - the second regulator has a 5-bit code from 3.00 V in 50 mV steps, reset 00110.
// - the first regulator has a 4-bit code in bits 3:0, reset 0100.
// - the third regulator has a 4-bit code in bits 3:0, reset 0110.
// - the fourth regulator has a 5-bit code from 3.20 V in 50 mV steps, reset 10000.
// - enabled channels start under the sequencer, afterwards each enable bit switches its channel.
// - a changed voltage code is reached one step at a time, 52.5 us or 105 us per step.
// - shutdown runs in reverse start-up order, or all channels at once when selected.
`timescale 1ns/1ps
`include "sdv_params.svh"
module sdv_seq_top
    import sdv_pkg::*;
#(
    parameter int TICK_CYCLES = `SDV_TICK_NS / `SDV_CLK_PERIOD_NS,
    parameter int TICK_W      = 13
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // settings held in neighbouring registers
    input  wire logic [5:0] delay_ch1_ch2,
    input  wire logic [7:0] channel_enable_bit,
    input  wire logic       voltage_step_time,
    input  wire logic       shutdown_order_select,
    // global enable pin
    input  wire logic       enable_pin,
    // channel controls
    output logic      [7:0] ch_enable,
    output logic      [7:0] soft_start_go,
    output logic            seq_done,
    // present voltage codes
    output logic      [3:0] ch1_voltage_code,
    output logic      [4:0] ch2_voltage_code,
    output logic      [3:0] ch3_voltage_code,
    output logic      [4:0] ch4_voltage_code
);

    // ======================================================================
    // registers
    logic [7:0] delay_ch3_ch4;
    logic [7:0] delay_load_switches;
    logic [7:0] delay_external_ldos;
    logic [7:0] voltage_code_ch1;
    logic [7:0] voltage_code_ch2;
    logic [7:0] voltage_code_ch3;
    logic [7:0] voltage_code_ch4;

    // software writes, reserved bits held at zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            delay_ch3_ch4       <= `SDV_RST_DLY34;
            delay_load_switches <= `SDV_RST_DLY56;
            delay_external_ldos <= `SDV_RST_DLY78;
            voltage_code_ch1    <= `SDV_RST_VOLT1;
            voltage_code_ch2    <= `SDV_RST_VOLT2;
            voltage_code_ch3    <= `SDV_RST_VOLT3;
            voltage_code_ch4    <= `SDV_RST_VOLT4;
        end else if (reg_wr) begin
            case (reg_addr)
                `SDV_ADDR_DLY34: delay_ch3_ch4 <= reg_wdata & `SDV_DLY_MASK;
                `SDV_ADDR_DLY56: delay_load_switches <= reg_wdata & `SDV_DLY_MASK;
                `SDV_ADDR_DLY78: delay_external_ldos <= reg_wdata & `SDV_DLY_MASK;
                `SDV_ADDR_VOLT1: voltage_code_ch1 <= reg_wdata & `SDV_V4_MASK;
                `SDV_ADDR_VOLT2: voltage_code_ch2 <= reg_wdata & `SDV_V5_MASK;
                `SDV_ADDR_VOLT3: voltage_code_ch3 <= reg_wdata & `SDV_V4_MASK;
                `SDV_ADDR_VOLT4: voltage_code_ch4 <= reg_wdata & `SDV_V5_MASK;
                default: ;
            endcase
        end
    end

    // read data, unmapped offsets read zero, held between reads
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `SDV_ADDR_DLY34: reg_rdata <= delay_ch3_ch4;
                `SDV_ADDR_DLY56: reg_rdata <= delay_load_switches;
                `SDV_ADDR_DLY78: reg_rdata <= delay_external_ldos;
                `SDV_ADDR_VOLT1: reg_rdata <= voltage_code_ch1;
                `SDV_ADDR_VOLT2: reg_rdata <= voltage_code_ch2;
                `SDV_ADDR_VOLT3: reg_rdata <= voltage_code_ch3;
                `SDV_ADDR_VOLT4: reg_rdata <= voltage_code_ch4;
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end

    // ======================================================================
    // delay code fields, channel order ch1..ch4, switch1, switch2, ldo1, ldo2
    sdv_delay_t ch3_delay_code;
    sdv_delay_t ch4_delay_code;
    sdv_delay_t switch1_delay_code;
    sdv_delay_t switch2_delay_code;
    sdv_delay_t extldo1_delay_code;
    sdv_delay_t extldo2_delay_code;
    sdv_delay_t channel_delay_code [`SDV_NCH];

    assign ch3_delay_code     = delay_ch3_ch4[`SDV_LO_LSB +: 3];
    assign ch4_delay_code     = delay_ch3_ch4[`SDV_HI_LSB +: 3];
    assign switch1_delay_code = delay_load_switches[`SDV_LO_LSB +: 3];
    assign switch2_delay_code = delay_load_switches[`SDV_HI_LSB +: 3];
    assign extldo1_delay_code = delay_external_ldos[`SDV_LO_LSB +: 3];
    assign extldo2_delay_code = delay_external_ldos[`SDV_HI_LSB +: 3];

    assign channel_delay_code[0] = delay_ch1_ch2[`SDV_LO_LSB +: 3];
    assign channel_delay_code[1] = delay_ch1_ch2[`SDV_HI_LSB +: 3];
    assign channel_delay_code[2] = ch3_delay_code;
    assign channel_delay_code[3] = ch4_delay_code;
    assign channel_delay_code[4] = switch1_delay_code;
    assign channel_delay_code[5] = switch2_delay_code;
    assign channel_delay_code[6] = extldo1_delay_code;
    assign channel_delay_code[7] = extldo2_delay_code;

    // delay code to a count of 52.5 us ticks
    function automatic sdv_ticks_t delay_ticks(input sdv_delay_t code);
        case (code)
            3'h0:    delay_ticks = `SDV_DLY_C0;
            3'h1:    delay_ticks = `SDV_DLY_C1;
            3'h2:    delay_ticks = `SDV_DLY_C2;
            3'h3:    delay_ticks = `SDV_DLY_C3;
            3'h4:    delay_ticks = `SDV_DLY_C4;
            3'h5:    delay_ticks = `SDV_DLY_C5;
            3'h6:    delay_ticks = `SDV_DLY_C6;
            default: delay_ticks = `SDV_DLY_C7;
        endcase
    endfunction : delay_ticks

    // ======================================================================
    // time base and pin synchroniser
    logic tick;
    logic en_meta;
    logic en_sync;
    logic en_prev;

    sdv_tick_div #(
        .CYCLES (TICK_CYCLES),
        .W      (TICK_W)
    ) u_tick (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (tick)
    );

    // two flops on the enable pin, edge taken from the second
    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
            en_prev <= 1'b0;
        end else begin
            en_meta <= enable_pin;
            en_sync <= en_meta;
            en_prev <= en_sync;
        end
    end

    // ======================================================================
    // sequencer
    sdv_state_e state;
    sdv_ticks_t elapsed;
    sdv_ticks_t span;
    sdv_ticks_t down_cnt;
    logic [7:0] run_mask;
    logic [7:0] started;
    logic       all_started;
    logic       leave_all;

    assign all_started = &(started | ~run_mask);
    assign leave_all   = ~en_sync & shutdown_order_select;

    // state, elapsed time from start and shutdown time
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state    <= SDV_IDLE;
            elapsed  <= 10'h000;
            span     <= 10'h000;
            down_cnt <= 10'h000;
            run_mask <= 8'h00;
        end else begin
            case (state)
                SDV_IDLE: begin
                    if (en_sync && !en_prev) begin
                        state    <= SDV_RUN;
                        elapsed  <= 10'h000;
                        run_mask <= channel_enable_bit;
                    end
                end
                SDV_RUN: begin
                    if (leave_all) begin
                        state <= SDV_IDLE;
                    end else if (!en_sync) begin
                        state    <= SDV_DOWN;
                        span     <= elapsed;
                        down_cnt <= 10'h000;
                    end else if (all_started) begin
                        state <= SDV_ON;
                        span  <= elapsed;
                    end else if (tick) begin
                        elapsed <= elapsed + 10'h001;
                    end
                end
                SDV_ON: begin
                    if (leave_all) begin
                        state <= SDV_IDLE;
                    end else if (!en_sync) begin
                        state    <= SDV_DOWN;
                        down_cnt <= 10'h000;
                    end
                end
                SDV_DOWN: begin
                    if (down_cnt >= span) begin
                        state <= SDV_IDLE;
                    end else if (tick) begin
                        down_cnt <= down_cnt + 10'h001;
                    end
                end
                default: begin
                    state <= SDV_IDLE;
                end
            endcase
        end
    end

    // sequence finished flag
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq_done <= 1'b0;
        end else begin
            seq_done <= (state == SDV_ON) && en_sync;
        end
    end

    // per channel enable and soft-start start pulse
    genvar gi;
    generate
        for (gi = 0; gi < `SDV_NCH; gi++) begin : g_ch
            sdv_ticks_t wait_ticks;
            logic       due;
            logic       off_due;
            logic       next_on;

            assign wait_ticks = delay_ticks(channel_delay_code[gi]);
            assign due        = run_mask[gi] && (wait_ticks <= elapsed);
            assign off_due    = ({1'b0, down_cnt} + {1'b0, wait_ticks}) >= {1'b0, span};
            assign started[gi] = due;

            // next enable level of this channel
            always_comb begin
                next_on = ch_enable[gi];
                case (state)
                    SDV_IDLE: next_on = 1'b0;
                    SDV_RUN:  next_on = leave_all ? 1'b0 : (ch_enable[gi] | (en_sync & due));
                    SDV_ON:   next_on = leave_all ? 1'b0 : (en_sync ? channel_enable_bit[gi] : ch_enable[gi]);
                    SDV_DOWN: next_on = ch_enable[gi] & ~off_due;
                    default:  next_on = 1'b0;
                endcase
            end

            // enable flop and one-cycle soft-start pulse on each turn-on
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    ch_enable[gi]     <= 1'b0;
                    soft_start_go[gi] <= 1'b0;
                end else begin
                    ch_enable[gi]     <= next_on;
                    soft_start_go[gi] <= next_on & ~ch_enable[gi];
                end
            end
        end
    endgenerate

    // ======================================================================
    // voltage stepping for the four regulators
    sdv_ramp_if rp [`SDV_NREG] ();
    sdv_vcode_t vtarget [`SDV_NREG];

    assign vtarget[0] = voltage_code_ch1[4:0];
    assign vtarget[1] = voltage_code_ch2[4:0];
    assign vtarget[2] = voltage_code_ch3[4:0];
    assign vtarget[3] = voltage_code_ch4[4:0];

    // reset level matches the register reset value
    function automatic sdv_vcode_t vreset(input int k);
        case (k)
            0:       vreset = 5'(`SDV_RST_VOLT1);
            1:       vreset = 5'(`SDV_RST_VOLT2);
            2:       vreset = 5'(`SDV_RST_VOLT3);
            default: vreset = 5'(`SDV_RST_VOLT4);
        endcase
    endfunction : vreset

    genvar gk;
    generate
        for (gk = 0; gk < `SDV_NREG; gk++) begin : g_reg
            assign rp[gk].target    = vtarget[gk];
            assign rp[gk].tick      = tick;
            assign rp[gk].step_long = voltage_step_time;

            sdv_vstep #(
                .RESET_CODE (vreset(gk))
            ) u_step (
                .core_clk (core_clk),
                .rst      (rst),
                .rp       (rp[gk])
            );
        end
    endgenerate

    // present codes, each a stepper flop
    assign ch1_voltage_code = rp[0].level[3:0];
    assign ch2_voltage_code = rp[1].level;
    assign ch3_voltage_code = rp[2].level[3:0];
    assign ch4_voltage_code = rp[3].level;

endmodule : sdv_seq_top

// [verification/sdv_seq_props.sv]
/*
 * Checker for the start-up delay and voltage code block.
 * Assumes it is bound to sdv_seq_top and sees only its ports.
 */
`timescale 1ns/1ps
module sdv_seq_props #(
    parameter int TICK_CYCLES = 5250
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // channel controls
    input wire logic [7:0] ch_enable,
    input wire logic [7:0] soft_start_go,
    input wire logic       seq_done,
    // present voltage codes
    input wire logic [3:0] ch1_voltage_code,
    input wire logic [4:0] ch2_voltage_code,
    input wire logic [3:0] ch3_voltage_code,
    input wire logic [4:0] ch4_voltage_code
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [15:0] gap;

    // cycles since the last move of the ch2 code
    always_ff @(posedge core_clk) begin
        if (rst || $changed(ch2_voltage_code))
            gap <= 16'h0000;
        else if (gap != 16'hFFFF)
            gap <= gap + 16'h0001;
    end

    // ==========================================================================
    // assertions
    chk_rst_outputs: assert property ($fell(rst) |-> ch_enable == 8'h00 && !seq_done && reg_rdata == 8'h00)
        else $error("outputs not reset");
    chk_rst_codes: assert property ($fell(rst) |-> ch1_voltage_code == 4'h4 && ch2_voltage_code == 5'h06
        && ch3_voltage_code == 4'h6 && ch4_voltage_code == 5'h10) else $error("codes not reset");
    chk_soft_pulse: assert property (!$past(rst) |-> soft_start_go == (ch_enable & ~$past(ch_enable)))
        else $error("bad soft start pulse");
    chk_step_size: assert property (!$past(rst) && $changed(ch2_voltage_code) |->
        5'(ch2_voltage_code - $past(ch2_voltage_code)) inside {5'h01, 5'h1F}) else $error("ch2 code jumped");
    chk_step_gap: assert property ($changed(ch2_voltage_code) && !$past(rst) |-> gap >= 16'(TICK_CYCLES - 1))
        else $error("ch2 step too soon");
    chk_dly_reserved: assert property (reg_rd && reg_addr inside {8'h08, 8'h09, 8'h0A} |=> reg_rdata[7:6] == 2'h0)
        else $error("delay reserved set");
    chk_volt4_reserved: assert property (reg_rd && reg_addr inside {8'h0B, 8'h0D} |=> reg_rdata[7:4] == 4'h0)
        else $error("volt4 reserved set");
    chk_volt5_reserved: assert property (reg_rd && reg_addr inside {8'h0C, 8'h0E} |=> reg_rdata[7:5] == 3'h0)
        else $error("volt5 reserved set");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("rdata not held");

    // main scenarios
    cover property (soft_start_go != 8'h00);
    cover property ($rose(seq_done));
    cover property ($changed(ch2_voltage_code) && !$past(rst));
endmodule : sdv_seq_props

bind sdv_seq_top sdv_seq_props #(.TICK_CYCLES(TICK_CYCLES)) i_sdv_seq_props (.core_clk, .rst, .reg_addr, .reg_rd,
    .reg_rdata, .ch_enable, .soft_start_go, .seq_done, .ch1_voltage_code, .ch2_voltage_code, .ch3_voltage_code,
    .ch4_voltage_code);

// [verification/sdv_seq_tb_top.sv]
/*
 * Self-checking testbench of the start-up delay and voltage code block.
 * Assumes a 4-cycle tick so that every delay code fits a short run.
 */
`timescale 1ns/1ps
module sdv_seq_tb_top;
    localparam int TK = 4;
    localparam logic [7:0] ADR [7] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
    localparam logic [7:0] DEF [7] = '{8'h00, 8'h10, 8'h01, 8'h04, 8'h06, 8'h06, 8'h10};
    localparam logic [7:0] MSK [7] = '{8'h3F, 8'h3F, 8'h3F, 8'h0F, 8'h1F, 8'h0F, 8'h1F};
    localparam int DLY [8] = '{0, 320, 40, 100, 120, 60, 160, 640};
    logic       core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, enable_pin = 1'b0;
    logic       voltage_step_time = 1'b0, shutdown_order_select = 1'b0, seq_done;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, channel_enable_bit = 8'hFF;
    logic [7:0] reg_rdata, ch_enable, soft_start_go;
    logic [5:0] delay_ch1_ch2 = 6'h30;
    logic [3:0] ch1_voltage_code, ch3_voltage_code;
    logic [4:0] ch2_voltage_code, ch4_voltage_code;
    int         n_mismatch = 0, n_checks = 0, cyc = 0;
    int         t_edge [8];

    sdv_seq_top #(.TICK_CYCLES(TK)) i_sdv_seq_top (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .delay_ch1_ch2, .channel_enable_bit, .voltage_step_time, .shutdown_order_select,
        .enable_pin, .ch_enable, .soft_start_go, .seq_done, .ch1_voltage_code, .ch2_voltage_code,
        .ch3_voltage_code, .ch4_voltage_code);

    // ==========================================================================
    // clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 15000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ==========================================================================
    // shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk) #1;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk) #1;
        reg_rd = 1'b0;
        chk(reg_rdata, exp, what);
    endtask : rd

    // first cycle at which each channel enable reaches pol
    task automatic watch(input logic pol, input int lim);
        t_edge = '{default: -1};
        for (int c = 0; c < lim; c++) begin
            @(posedge core_clk) #1;
            for (int k = 0; k < 8; k++)
                if (t_edge[k] < 0 && ch_enable[k] === pol)
                    t_edge[k] = c;
        end
    endtask : watch

    // gaps between each channel and the zero-delay channel
    task automatic judge(input logic up);
        int d;
        for (int k = 0; k < 8; k++) begin
            d = up ? t_edge[k] - t_edge[0] : t_edge[0] - t_edge[k];
            n_checks++;
            if (t_edge[k] < 0 || d < (DLY[k] - 2) * TK || d > (DLY[k] + 2) * TK) begin
                n_mismatch++;
                $display("Error at %0t: ch %0d gap %0d", $time, k, d);
            end
        end
    endtask : judge

    // ==========================================================================
    // scenarios
    task automatic t_regs;
        for (int i = 0; i < 7; i++)
            rd(ADR[i], DEF[i], "reset value");
        for (int i = 0; i < 7; i++)
            wr(ADR[i], 8'hFF);
        wr(8'h0F, 8'hFF);
        for (int i = 0; i < 7; i++)
            rd(ADR[i], MSK[i], "written value");
        rd(8'h0F, 8'h00, "unmapped read");
        rd(8'h07, 8'h00, "unmapped read");
        for (int i = 0; i < 7; i++)
            wr(ADR[i], DEF[i]);
        $display("test registers done");
    endtask : t_regs

    task automatic t_start;
        wr(8'h08, 8'h19);
        wr(8'h09, 8'h14);
        wr(8'h0A, 8'h3D);
        enable_pin = 1'b1;
        watch(1'b1, 2700);
        chk((t_edge[0] >= 3 && t_edge[0] <= 5) ? 8'h01 : 8'h00, 8'h01, "ch1 start");
        judge(1'b1);
        chk({7'h00, seq_done}, 8'h01, "sequence done");
        channel_enable_bit = 8'hFB;
        repeat (3) @(posedge core_clk) #1;
        chk(ch_enable, 8'hFB, "ch off");
        channel_enable_bit = 8'hFF;
        @(posedge core_clk) #1;
        chk(ch_enable, 8'hFF, "ch on");
        chk(soft_start_go, 8'h04, "soft pulse");
        $display("test start-up done");
    endtask : t_start

    task automatic t_stop;
        enable_pin = 1'b0;
        watch(1'b0, 2700);
        judge(1'b0);
        enable_pin = 1'b1;
        watch(1'b1, 2700);
        judge(1'b1);
        shutdown_order_select = 1'b1;
        enable_pin = 1'b0;
        watch(1'b0, 10);
        for (int k = 1; k < 8; k++)
            chk(8'(t_edge[k]), 8'(t_edge[0]), "all off together");
        chk(ch_enable, 8'h00, "all off");
        $display("test shutdown done");
    endtask : t_stop

    task automatic vstep(input logic lng, input logic [4:0] tgt, input int steps);
        int c;
        voltage_step_time = lng;
        wr(8'h0C, {3'h0, tgt});
        for (c = 0; c < 80 && ch2_voltage_code !== tgt; c++)
            @(posedge core_clk) #1;
        chk({3'h0, ch2_voltage_code}, {3'h0, tgt}, "ch2 code");
        chk((c >= (steps - 1) * TK * (lng + 1) && c <= (steps + 1) * TK * (lng + 1)) ? 8'h01 : 8'h00,
            8'h01, "ch2 step pacing");
    endtask : vstep

    task automatic t_volt;
        vstep(1'b0, 5'h08, 2);
        vstep(1'b1, 5'h05, 3);
        wr(8'h0B, 8'h02);
        wr(8'h0D, 8'h09);
        wr(8'h0E, 8'h12);
        repeat (60) @(posedge core_clk) #1;
        chk({4'h0, ch1_voltage_code}, 8'h02, "ch1 code");
        chk({4'h0, ch3_voltage_code}, 8'h09, "ch3 code");
        chk({3'h0, ch4_voltage_code}, 8'h12, "ch4 code");
        $display("test voltage steps done");
    endtask : t_volt

    task automatic t_reset_mid;
        wr(8'h08, 8'h18);
        channel_enable_bit = 8'hFB;
        enable_pin = 1'b1;
        repeat (20) @(posedge core_clk) #1;
        chk(ch_enable & 8'h05, 8'h01, "ch3 masked");
        rst = 1'b1;
        enable_pin = 1'b0;
        repeat (12) @(posedge core_clk) #1;
        rst = 1'b0;
        chk(ch_enable, 8'h00, "reset off");
        chk({3'h0, ch2_voltage_code}, 8'h06, "reset ch2");
        rd(8'h0A, 8'h01, "reset delay");
        $display("test mid-run reset done");
    endtask : t_reset_mid

    // ==========================================================================
    // main sequence and verdict
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    initial begin
        repeat (12) @(posedge core_clk) #1;
        rst = 1'b0;
        t_regs();
        t_start();
        t_stop();
        t_volt();
        t_reset_mid();
        conclude();
    end
endmodule : sdv_seq_tb_top
